// ### conv_ctrl_pkg.sv
// package: register map, field layout and codes of the converter control block
package conv_ctrl_pkg;
  // byte addresses (printed offsets not all multiples of four: index times four)
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h06;
  localparam logic [7:0] IDX_IN_REF_SEL = 8'h07;
  localparam logic [7:0] IDX_CTRL_B = 8'h08;
  localparam logic [7:0] IDX_RESULT = 8'h09;
  localparam logic [7:0] IDX_ROUTE = 8'h0a;
  localparam logic [11:0] ADDR_CTRL_STATUS = {2'h0, IDX_CTRL_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IN_REF_SEL = {2'h0, IDX_IN_REF_SEL, 2'h0};
  localparam logic [11:0] ADDR_CTRL_B = {2'h0, IDX_CTRL_B, 2'h0};
  localparam logic [11:0] ADDR_RESULT = {2'h0, IDX_RESULT, 2'h0};
  localparam logic [11:0] ADDR_ROUTE = {2'h0, IDX_ROUTE, 2'h0};
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0] RST_IN_REF_SEL = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  // control/status field positions
  localparam int B_EN = 7;
  localparam int B_START = 6;
  localparam int B_AUTO = 5;
  localparam int B_DONE = 4;
  localparam int B_IRQEN = 3;
  // input/reference select field positions
  localparam int B_REF_HI = 7;
  localparam int B_REF_LO = 6;
  localparam int B_LALIGN = 5;
  localparam int B_CHAN_HI = 4;
  // control b: bit3 chan_sel_high, bit4 ref_sel_high, bit5 gain_hi, 2:0 trigger_source_sel
  localparam int B_CB_CHAN = 3;
  localparam int B_CB_REF = 4;
  localparam int B_CB_GAIN = 5;
  // conversion lengths in converter clock cycles
  localparam logic [4:0] LONG_CYC = 5'h19;
  localparam logic [4:0] SHORT_CYC = 5'h0d;
  // reference codes
  typedef enum logic [2:0] {
    REF_SUPPLY, REF_EXT_PIN, REF_INT_1V1, REF_RESERVED, REF_INT_2V56, REF_INT_2V56_BYP
  } ref_src_e;
  // analog front-end steering
  typedef struct packed {
    logic diff;
    logic [3:0] pos_in;
    logic [3:0] neg_in;
    logic [5:0] gain_x;
    logic int_1v1;
    logic zero_v;
    logic temp_en;
  } route_s;
  localparam logic [5:0] CH_LAST_SE = 6'h0a;
  localparam logic [5:0] CH_1V1 = 6'h1e;
  localparam logic [5:0] CH_0V = 6'h1f;
  localparam logic [5:0] CH_TEMP = 6'h3f;
  localparam logic [3:0] TEMP_INPUT = 4'hb;
endpackage : conv_ctrl_pkg

// ### conv_route_dec.sv
// module: channel code and reference pattern decoder
`timescale 1ns/10ps
`default_nettype none
module conv_route_dec (
  // codes
  input wire logic [5:0] chan_code,
  input wire logic [2:0] ref_code,
  input wire logic gain_hi,
  // decoded
  output conv_ctrl_pkg::route_s route,
  output conv_ctrl_pkg::ref_src_e ref_src
);
  import conv_ctrl_pkg::*;
  // fixed pairs per code 0x0b..0x1d: {pos[3:0], neg[3:0], gain20}
  logic [8:0] fixed_tab [0:18];
  assign fixed_tab = '{
    9'h003, 9'h002, 9'h023, 9'h043, 9'h042, 9'h046, 9'h067, 9'h087, 9'h086,
    9'h08b, 9'h08a, 9'h0ab, 9'h0cb, 9'h0ca, 9'h113, 9'h112, 9'h133, 9'h153, 9'h152};
  // dual gain pairs per code 0x20..0x3e: {pos[3:0], neg[3:0], lowgain}
  logic [8:0] dual_tab [0:30];
  assign dual_tab = '{
    9'h002, 9'h003, 9'h020, 9'h021, 9'h024, 9'h025, 9'h042, 9'h043,
    9'h040, 9'h041, 9'h004, 9'h005, 9'h08a, 9'h08b, 9'h0a8, 9'h0a9,
    9'h0ac, 9'h0ad, 9'h0ca, 9'h0cb, 9'h0c8, 9'h0c9, 9'h08c, 9'h08d,
    9'h000, 9'h001, 9'h022, 9'h044, 9'h088, 9'h0aa, 9'h0cc};
  wire [4:0] fix_idx = 5'(chan_code - 6'h0b);
  wire [4:0] dual_idx = chan_code[4:0];
  wire [8:0] fix_e = fixed_tab[(fix_idx > 5'd18) ? 5'd0 : fix_idx];
  wire [8:0] dual_e = (dual_idx == 5'h1f) ? 9'h0 : dual_tab[dual_idx];
  wire is_se = chan_code <= CH_LAST_SE;
  wire is_fixed = !chan_code[5] && !is_se && chan_code < CH_1V1;
  wire is_dual = chan_code[5] && chan_code != CH_TEMP;
  // pin codes need four bits each: pins 8..10 sit in the fixed pairs
  wire [3:0] dpos = dual_e[8:5];
  wire [3:0] dneg = dual_e[4:1];
  wire dual_lo = dual_e[0];
  always_comb begin
    route = '0;
    if (is_se) begin
      route.pos_in = chan_code[3:0];
    end else if (is_fixed) begin
      route.diff = 1'b1;
      route.pos_in = fix_e[8:5];
      route.neg_in = fix_e[4:1];
      route.gain_x = fix_e[0] ? 6'h14 : 6'h01;
    end else if (is_dual) begin
      route.diff = 1'b1;
      route.pos_in = dpos;
      route.neg_in = dneg;
      if (dual_lo) route.gain_x = gain_hi ? 6'h08 : 6'h01;
      else route.gain_x = gain_hi ? 6'h20 : 6'h14;
    end else if (chan_code == CH_1V1) begin
      route.int_1v1 = 1'b1;
    end else if (chan_code == CH_0V) begin
      route.zero_v = 1'b1;
    end else begin
      route.pos_in = TEMP_INPUT;
      route.temp_en = 1'b1;
    end
  end
  always_comb begin
    case (ref_code)
      3'b000, 3'b100: ref_src = REF_SUPPLY;
      3'b001, 3'b101: ref_src = REF_EXT_PIN;
      3'b010: ref_src = REF_INT_1V1;
      3'b110: ref_src = REF_INT_2V56;
      3'b111: ref_src = REF_INT_2V56_BYP;
      default: ref_src = REF_RESERVED;
    endcase
  end
endmodule // conv_route_dec
`default_nettype wire

// ### conv_ctrl_regs.sv
// module: converter control and status registers with apb slave
//
// Notes on behaviour
// - three-bit reference code decodes to supply, pin, 1.1V, 2.56V, 2.56V bypassed.
// - reference changes during a conversion apply only after it completes.
// - conversion after a reference change lasts 25 converter clocks.
// - alignment bit shifts the presented result immediately, even mid-conversion.
// - codes 0..10 pick single inputs; 30 picks 1.1V, 31 picks 0V.
// - codes 11..29 pick fixed differential pairs with 1x or 20x gain.
// - codes 32..62 pick differential pairs with selectable dual gain.
// - some codes route one pin to both inputs for offset measurement.
// - code 63 picks channel 11 and enables the temperature sensor.
// - channel changes during a conversion apply only after it completes.
// - enable turns converter on; clearing it aborts a running conversion.
// - start write begins one conversion; free running needs only the first.
// - first conversion after enabling takes 25 clocks, later ones 13.
// - start reads one while busy; writing zero does nothing.
// - auto-trigger starts a conversion on each trigger rising edge that comes while no conversion is busy.
// - done flag sets when a conversion finishes and result updates.
// - done flag clears on vector acknowledge or writing one; zero ignored.
// - interrupt requests only with flag, enable and global enable set.
// - prescaler codes give 2,2,4,8,16,32,64,128 system clocks per converter clock.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module conv_ctrl_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor side
  input wire logic global_irq_en,
  input wire logic irq_ack,
  output logic irq_req,
  // trigger sources, from pins
  input wire logic [7:0] trig_src,
  // analog front end
  input wire logic [9:0] raw_result,
  output conv_ctrl_pkg::route_s route,
  output conv_ctrl_pkg::ref_src_e ref_src,
  output logic conv_on,
  output logic conv_clk_en,
  output logic sample_go
);
  import conv_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [7:0] ctrl_ff, insel_ff, ctlb_ff;
  logic [5:0] chan_act_ff;
  logic [2:0] ref_act_ff;
  logic [9:0] res_ff;
  logic busy_ff, long_ff, done_ff, irq_ff;
  logic [4:0] cyc_ff;
  logic [6:0] pre_ff;
  logic [7:0] t0_ff, t1_ff, t2_ff, t3_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff, pready_ff;
  logic clk_en_ff;
  route_s route_ff;
  ref_src_e ref_ff;
  route_s route_dec;
  ref_src_e ref_dec;

  wire acc = psel && penable && pready_ff;
  wire wr = acc && pwrite;
  wire hit_cs = paddr == ADDR_CTRL_STATUS;
  wire hit_is = paddr == ADDR_IN_REF_SEL;
  wire hit_cb = paddr == ADDR_CTRL_B;
  wire hit_rs = paddr == ADDR_RESULT;
  wire hit_rt = paddr == ADDR_ROUTE;
  wire hit_any = hit_cs || hit_is || hit_cb || hit_rs || hit_rt;
  wire wr_cs = wr && hit_cs;
  wire wr_is = wr && hit_is;
  wire wr_cb = wr && hit_cb;
  wire [7:0] wb = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // converter clock prescaler
  wire [2:0] div_code = ctrl_ff[2:0];
  wire [6:0] div_max = (div_code <= 3'h1) ? 7'h01 : 7'((8'h01 << div_code) - 8'h01);
  wire tick = pre_ff >= div_max;
  wire [6:0] nxt_pre = (!ctrl_ff[B_EN] || tick) ? 7'h00 : 7'(pre_ff + 7'h01);

  ////////////////////////////////////////////////////////////////////////////////
  // trigger edge (pins: four flops, edge once second and third agree)
  wire [2:0] trig_sel = ctlb_ff[2:0];
  // rise counts once second and third agree high while the fourth is still low
  wire trig_rise = t1_ff[trig_sel] && t2_ff[trig_sel] && !t3_ff[trig_sel];
  wire en_now = wr_cs ? wb[B_EN] : ctrl_ff[B_EN];
  wire first_en = wr_cs && wb[B_EN] && !ctrl_ff[B_EN];
  wire sw_start = wr_cs && wb[B_START] && wb[B_EN];
  wire auto_start = ctrl_ff[B_AUTO] && trig_rise && ctrl_ff[B_EN];
  wire start_req = (sw_start || auto_start) && !busy_ff;
  wire finish = busy_ff && tick && cyc_ff == 5'h01;
  wire abort = !en_now;
  wire free_run = ctrl_ff[B_AUTO] && trig_sel == 3'h0;
  wire [2:0] ref_new = {ctlb_ff[B_CB_REF], insel_ff[B_REF_HI:B_REF_LO]};
  wire [5:0] chan_new = {ctlb_ff[B_CB_CHAN], insel_ff[4:0]};
  wire ref_changed = ref_new != ref_act_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // conversion engine
  logic nxt_busy, nxt_long, nxt_done;
  logic [4:0] nxt_cyc;
  logic [9:0] nxt_res;
  always_comb begin
    nxt_busy = busy_ff;
    nxt_long = long_ff;
    nxt_cyc = cyc_ff;
    nxt_res = res_ff;
    if (first_en) nxt_long = 1'b1;
    if ((!busy_ff || finish) && ref_changed) nxt_long = 1'b1;
    if (abort) begin
      nxt_busy = 1'b0;
      nxt_cyc = 5'h00;
    end else if (finish) begin
      nxt_res = raw_result;
      nxt_busy = free_run;
      nxt_cyc = nxt_long ? LONG_CYC : SHORT_CYC;
      if (free_run) nxt_long = 1'b0;
    end else if (start_req) begin
      nxt_busy = 1'b1;
      nxt_cyc = (nxt_long || first_en || ref_changed) ? LONG_CYC : SHORT_CYC;
      nxt_long = 1'b0;
    end else if (busy_ff && tick) begin
      nxt_cyc = 5'(cyc_ff - 5'h01);
    end
    nxt_done = done_ff;
    if (irq_ack || (wr_cs && wb[B_DONE])) nxt_done = 1'b0;
    if (finish && !abort) nxt_done = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      long_ff <= 1'b0;
      cyc_ff <= 5'h00;
      res_ff <= 10'h000;
      done_ff <= 1'b0;
      pre_ff <= 7'h00;
    end else begin
      busy_ff <= nxt_busy;
      long_ff <= nxt_long;
      cyc_ff <= nxt_cyc;
      res_ff <= nxt_res;
      done_ff <= nxt_done;
      pre_ff <= nxt_pre;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers and held selections
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_ff <= RST_CTRL_STATUS;
      insel_ff <= RST_IN_REF_SEL;
      ctlb_ff <= RST_CTRL_B;
      chan_act_ff <= 6'h00;
      ref_act_ff <= 3'h0;
      t0_ff <= 8'h00;
      t1_ff <= 8'h00;
      t2_ff <= 8'h00;
      t3_ff <= 8'h00;
    end else begin
      if (wr_cs) ctrl_ff <= {wb[7], 1'b0, wb[5], 1'b0, wb[3:0]};
      if (wr_is) insel_ff <= wb;
      if (wr_cb) ctlb_ff <= wb;
      if (!busy_ff || finish) begin
        chan_act_ff <= chan_new;
        ref_act_ff <= ref_new;
      end
      t0_ff <= trig_src;
      t1_ff <= t0_ff;
      t2_ff <= t1_ff;
      t3_ff <= t2_ff;
    end
  end

  conv_route_dec u_dec (
    .chan_code(chan_act_ff),
    .ref_code(ref_act_ff),
    .gain_hi(ctlb_ff[B_CB_GAIN]),
    .route(route_dec),
    .ref_src(ref_dec)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read mux; result alignment applies at read time
  wire [15:0] res_view = insel_ff[B_LALIGN] ? {res_ff, 6'h00} : {6'h00, res_ff};
  wire [7:0] cs_view = {ctrl_ff[7], busy_ff, ctrl_ff[5], done_ff, ctrl_ff[3:0]};
  wire [31:0] rd_mux = hit_cs ? {24'h0, cs_view} :
                       hit_is ? {24'h0, insel_ff} :
                       hit_cb ? {24'h0, ctlb_ff} :
                       hit_rs ? {16'h0, res_view} :
                       hit_rt ? {14'h0, route_dec} : 32'h0;
  wire irq_next = nxt_done && ctrl_ff[B_IRQEN] && global_irq_en;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
      pready_ff <= 1'b0;
      irq_ff <= 1'b0;
      clk_en_ff <= 1'b0;
      route_ff <= '0;
      ref_ff <= REF_SUPPLY;
    end else begin
      pready_ff <= psel && !penable;
      if (psel && !penable) begin
        prdata_ff <= pwrite ? 32'h0 : rd_mux;
        pslverr_ff <= !hit_any;
      end
      irq_ff <= irq_next;
      clk_en_ff <= tick && ctrl_ff[B_EN];
      route_ff <= route_dec;
      ref_ff <= ref_dec;
    end
  end

  logic sample_ff, on_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_ff <= 1'b0;
      on_ff <= 1'b0;
    end else begin
      // free running restarts at finish without busy ever dropping
      sample_ff <= (nxt_busy && !busy_ff) || (finish && free_run && !abort);
      on_ff <= en_now;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq_req = irq_ff;
  assign route = route_ff;
  assign ref_src = ref_ff;
  assign conv_on = on_ff;
  assign conv_clk_en = clk_en_ff;
  assign sample_go = sample_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  AST_ABORT: assert property (@(posedge core_clk) disable iff (rst)
    (wr_cs && !wb[B_EN]) |=> !busy_ff) else $error("abort did not stop conversion");
  AST_DONE_SET: assert property (@(posedge core_clk) disable iff (rst)
    (finish && !abort) |=> done_ff) else $error("done flag not set");
  AST_DONE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (done_ff && !irq_ack && !(wr_cs && wb[B_DONE])) |=> done_ff)
    else $error("done flag lost");
  AST_IRQ: assert property (@(posedge core_clk) disable iff (rst)
    irq_req |-> $past(done_ff || finish) && $past(global_irq_en))
    else $error("irq without cause");
  AST_LONG_FIRST: assert property (@(posedge core_clk) disable iff (rst)
    (first_en && sw_start) |=> cyc_ff == LONG_CYC) else $error("first conversion not long");
  AST_CHAN_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (busy_ff && !finish) |=> $stable(chan_act_ff)) else $error("channel changed mid-run");
  AST_REF_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (busy_ff && !finish) |=> $stable(ref_act_ff)) else $error("reference changed mid-run");
  AST_START_RD: assert property (@(posedge core_clk) disable iff (rst)
    (psel && !penable && !pwrite && hit_cs) |=> prdata[B_START] == $past(busy_ff))
    else $error("start bit read wrong");
  AST_DIV: assert property (@(posedge core_clk) disable iff (rst)
    (ctrl_ff[B_EN] && div_code == 3'h2 && tick) |-> ##1 !tick ##1 !tick ##1 !tick)
    else $error("prescaler period wrong");
  COV_FINISH: cover property (@(posedge core_clk) finish);
  COV_AUTO: cover property (@(posedge core_clk) auto_start);
  COV_ABORT: cover property (@(posedge core_clk) busy_ff && abort);
endmodule // conv_ctrl_regs
`default_nettype wire

// ### conv_front_model.sv
// analog front-end stand-in: a fresh sample value for each conversion
`timescale 1ns/10ps
`default_nettype none
module conv_front_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // from the block
  input wire logic sample_go,
  // to the block
  output logic [9:0] raw_result
);
  ////////////////////////////////////////////////////////////////////////////
  // held through a whole conversion, so a late sample point still reads it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw_result <= 10'h2a3;
    end else if (sample_go) begin
      raw_result <= raw_result + 10'h0b5;
    end
  end
endmodule // conv_front_model
`default_nettype wire

// ### test_analog_converter_control_regs.sv
// self-checking bench for the converter control registers
`timescale 1ns/10ps
`default_nettype none
module test_analog_converter_control_regs;
  import conv_ctrl_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, irq_req, conv_on, conv_clk_en, sample_go;
  logic global_irq_en = 0;
  logic irq_ack = 0;
  logic [7:0] trig_src = 8'h0;
  logic [9:0] raw_result;
  route_s route;
  ref_src_e ref_src;
  int errors = 0;
  int checks = 0;
  int long_n, short_n, len, sg_cnt;
  wire logic [14:0] rsel = {route.diff, route.pos_in, route.neg_in, route.gain_x};
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (sample_go === 1'b1) sg_cnt++;
  ////////////////////////////////////////////////////////////////////////////
  conv_ctrl_regs dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
    .trig_src(trig_src), .raw_result(raw_result), .route(route), .ref_src(ref_src),
    .conv_on(conv_on), .conv_clk_en(conv_clk_en), .sample_go(sample_go));
  conv_front_model front_u (.core_clk(core_clk), .rst(rst), .sample_go(sample_go),
    .raw_result(raw_result));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tmo;
    errors++;
    wrap_up();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // entered just after an edge; one idle edge after, so no signal flips twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  // converter clocks from a start write until the interrupt line rises
  task automatic conv_len(output int p);
    int n;
    p = 0;
    cyc(2);
    for (n = 0; irq_req !== 1'b1; n++) begin
      if (n > 9000) tmo();
      @(posedge core_clk);
      if (conv_clk_en === 1'b1) p++;
    end
  endtask
  task automatic setch(input logic [5:0] c, input logic g);
    apb(1, ADDR_CTRL_B, {26'h0, g, 1'b0, c[5], 3'h0});
    apb(1, ADDR_IN_REF_SEL, {27'h0, c[4:0]});
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, ADDR_CTRL_STATUS, 0);
    chk("ctrl_status rst", rd, 32'h0);
    apb(0, ADDR_IN_REF_SEL, 0);
    chk("in_ref_sel rst", rd, 32'h0);
    apb(1, ADDR_IN_REF_SEL, 32'h25);
    apb(0, ADDR_IN_REF_SEL, 0);
    chk("in_ref_sel rw", rd, 32'h25);
    apb(0, 12'h03c, 0);
    chk("unmapped err", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_ref;
    // reserved pattern only read back, never converted with
    ref_src_e e [8] = '{REF_SUPPLY, REF_EXT_PIN, REF_INT_1V1, REF_RESERVED,
      REF_SUPPLY, REF_EXT_PIN, REF_INT_2V56, REF_INT_2V56_BYP};
    for (int i = 0; i < 8; i++) begin
      apb(1, ADDR_CTRL_B, {27'h0, i[2], 4'h0});
      apb(1, ADDR_IN_REF_SEL, {24'h0, i[1:0], 6'h0});
      cyc(3);
      chk("ref_src", ref_src, e[i]);
    end
    $display("test reference done");
  endtask
  task automatic t_chan;
    for (int i = 0; i <= 10; i++) begin
      setch(i[5:0], 1'b0);
      chk("single input", {route.diff, route.pos_in}, {1'b0, i[3:0]});
    end
    setch(6'h0b, 1'b0);
    chk("pair 20x", rsel, {1'b1, 4'h0, 4'h1, 6'h14});
    setch(6'h0c, 1'b0);
    chk("pair 1x", rsel, {1'b1, 4'h0, 4'h1, 6'h01});
    setch(6'h0d, 1'b0);
    chk("same pin", rsel, {1'b1, 4'h1, 4'h1, 6'h14});
    setch(6'h20, 1'b0);
    chk("dual low", rsel, {1'b1, 4'h0, 4'h1, 6'h14});
    setch(6'h21, 1'b1);
    chk("dual high", rsel, {1'b1, 4'h0, 4'h1, 6'h08});
    setch(CH_1V1, 1'b0);
    chk("1v1 level", route.int_1v1, 32'h1);
    setch(CH_0V, 1'b0);
    chk("0v level", route.zero_v, 32'h1);
    setch(CH_TEMP, 1'b0);
    chk("temp", {route.temp_en, route.diff, route.pos_in}, {2'h2, TEMP_INPUT});
    apb(1, ADDR_IN_REF_SEL, 32'h9f);
    cyc(3);
    chk("temp ref", ref_src, REF_INT_1V1);
    chk("temp kept", route.temp_en, 32'h1);
    $display("test channel done");
  endtask
  task automatic t_conv;
    global_irq_en <= 1;
    setch(6'h00, 1'b0);
    apb(1, ADDR_CTRL_STATUS, 32'hc8);
    conv_len(long_n);
    apb(1, ADDR_CTRL_STATUS, 32'hd8);
    conv_len(short_n);
    chk("long minus short", long_n - short_n, 12);
    apb(0, ADDR_CTRL_STATUS, 0);
    chk("done status", rd, 32'h98);
    apb(0, ADDR_RESULT, 0);
    chk("right aligned", rd, {22'h0, raw_result});
    apb(1, ADDR_IN_REF_SEL, 32'h20);
    apb(0, ADDR_RESULT, 0);
    chk("left aligned", rd, {16'h0, raw_result, 6'h0});
    apb(1, ADDR_IN_REF_SEL, 32'h0);
    $display("test conversion done");
  endtask
  task automatic t_flag;
    global_irq_en <= 0;
    cyc(3);
    chk("irq global off", irq_req, 32'h0);
    global_irq_en <= 1;
    cyc(3);
    chk("irq on", irq_req, 32'h1);
    apb(1, ADDR_CTRL_STATUS, 32'h88);
    apb(0, ADDR_CTRL_STATUS, 0);
    chk("flag kept", rd[4], 32'h1);
    apb(1, ADDR_CTRL_STATUS, 32'h98);
    apb(0, ADDR_CTRL_STATUS, 0);
    chk("flag cleared", rd[4], 32'h0);
    chk("irq off", irq_req, 32'h0);
    apb(1, ADDR_CTRL_STATUS, 32'hc8);
    apb(0, ADDR_CTRL_STATUS, 0);
    chk("busy start", rd[6], 32'h1);
    conv_len(len);
    irq_ack <= 1;
    @(posedge core_clk);
    irq_ack <= 0;
    cyc(2);
    apb(0, ADDR_CTRL_STATUS, 0);
    chk("ack clears", rd[4], 32'h0);
    $display("test flag done");
  endtask
  task automatic t_chg;
    apb(1, ADDR_CTRL_STATUS, 32'hc8);
    apb(1, ADDR_IN_REF_SEL, 32'h45);
    chk("ref held", ref_src, REF_SUPPLY);
    chk("chan held", route.pos_in, 32'h0);
    conv_len(len);
    cyc(2);
    chk("ref applied", ref_src, REF_EXT_PIN);
    chk("chan applied", route.pos_in, 32'h5);
    apb(1, ADDR_CTRL_STATUS, 32'hd8);
    conv_len(len);
    chk("long after ref change", len, long_n);
    $display("test change done");
  endtask
  task automatic t_abort;
    chk("on", conv_on, 32'h1);
    apb(1, ADDR_CTRL_STATUS, 32'hd8);
    cyc(4);
    apb(1, ADDR_CTRL_STATUS, 32'h08);
    chk("off", conv_on, 32'h0);
    apb(0, ADDR_CTRL_STATUS, 0);
    chk("start after abort", rd[6], 32'h0);
    apb(1, ADDR_CTRL_STATUS, 32'h88);
    cyc(100);
    chk("no done", irq_req, 32'h0);
    $display("test abort done");
  endtask
  task automatic t_div;
    int d [8] = '{2, 2, 4, 8, 16, 32, 64, 128};
    int g;
    for (int i = 0; i < 8; i++) begin
      apb(1, ADDR_CTRL_STATUS, 32'h0);
      apb(1, ADDR_CTRL_STATUS, 32'hd0 | i);
      for (g = 0; conv_clk_en !== 1'b1; g++) begin
        if (g > 300) tmo();
        @(posedge core_clk);
      end
      g = 0;
      do begin
        @(posedge core_clk);
        g++;
      end while (conv_clk_en !== 1'b1 && g < 300);
      chk("divider", g, d[i]);
    end
    $display("test divider done");
  endtask
  task automatic t_auto;
    apb(1, ADDR_CTRL_STATUS, 32'h0);
    apb(1, ADDR_CTRL_B, 32'h0);
    sg_cnt = 0;
    apb(1, ADDR_CTRL_STATUS, 32'hc0);
    cyc(200);
    chk("single", sg_cnt, 1);
    apb(1, ADDR_CTRL_STATUS, 32'h0);
    sg_cnt = 0;
    apb(1, ADDR_CTRL_STATUS, 32'he0);
    cyc(200);
    chk("free running", sg_cnt > 2, 1);
    apb(1, ADDR_CTRL_STATUS, 32'h0);
    apb(1, ADDR_CTRL_B, 32'h1);
    apb(1, ADDR_CTRL_STATUS, 32'ha0);
    sg_cnt = 0;
    repeat (2) begin
      trig_src <= 8'h02;
      cyc(4);
      trig_src <= 8'h00;
      cyc(100);
    end
    chk("trigger edges", sg_cnt, 2);
    $display("test trigger done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    t_reset();
    t_ref();
    t_chan();
    t_conv();
    t_flag();
    t_chg();
    t_abort();
    t_div();
    t_auto();
    wrap_up();
  end
  initial begin
    #400000;
    tmo();
  end
endmodule // test_analog_converter_control_regs
`default_nettype wire
